// ==== rtl/ipf_pkg.sv ====
// Package for the sample input port queue: register map, fields, carriers.
package ipf_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_QUEUE_HEAD = 8'h00;
  localparam logic [7:0] OFS_STATUS_MAIN = 8'h04;
  localparam logic [7:0] OFS_STATUS_INDEX = 8'h08;
  localparam logic [7:0] OFS_PORT_CTRL = 8'h0c;
  // ==========================================================
  // Control register fields
  localparam int CTL_THR_LSB = 0;
  localparam int CTL_THR_W = 4;
  localparam int CTL_STALL_DIS = 4;
  localparam int CTL_XFER_EN = 5;
  localparam int CTL_OVF_CLR = 6;
  localparam int CTL_PORT_EN = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [3:0] THR_MAX = 4'h7;
  // ==========================================================
  // Main status fields
  localparam int ST_PING_LSB = 0;
  localparam int ST_OVF_LSB = 8;
  localparam int ST_XFER_LSB = 17;
  localparam int ST_FILL_LSB = 28;
  // Index status fields
  localparam int IX_WR_LSB = 0;
  localparam int IX_RD_LSB = 4;
  // ==========================================================
  // Queue geometry
  localparam int NCHAN = 8;
  localparam int DEPTH = 8;
  localparam logic [3:0] FILL_FULL = 4'h8;
  localparam logic [3:0] IDX_MAX = 4'h8;
  // Queue entry as read at the head register
  typedef struct packed {
    logic [27:0] serialSampleBits;
    logic stereoSideFlag;
    logic [2:0] sourceChannelTag;
  } ipf_entry_t;
  // Sample arriving from a serial decoder or the parallel capture path
  typedef struct packed {
    logic fromParallel;
    ipf_entry_t entry;
  } ipf_sample_t;
endpackage : ipf_pkg

// ==== rtl/ipf_input_port_fifo.sv ====
// Output side and status logic of the eight-entry sample queue.
//
// Summary of operation
// - Eight-entry queue; head shows oldest entry
// - Entry bits 2-0 carry source channel
// - Parallel entries: tag and side meaningless
// - Entry bit 3 is stereo side flag
// - Entry bits 31-4 hold left-aligned sample
// - Main status register is read-only
// - Status bits 7-0: ping-pong activity per channel
// - Status bits 15-8: sticky per-channel overflow
// - Bits 24-17 set by enable, until done
// - Activity drops when transfers complete
// - Channels without intended transfer read high
// - Bits 31-28 give queue fill level
// - Core may write queue; index register tracks
// - Index bits 3-0 count core writes
// - Index bits 7-4 count core reads
// - Control bit 6 write-one clears overflow
// - Fill above threshold raises interrupt
// - Enable falling flushes; disabled blocks entry
// - Empty read/full write stall unless disabled
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ipf_input_port_fifo #(
  parameter int NCH = ipf_pkg::NCHAN
) (
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic regRdValid,
  output logic coreStall,
  // Sample write side
  input wire logic sampleValid,
  input wire ipf_pkg::ipf_sample_t sampleIn,
  // Transfer engine drain side
  input wire logic dmaPop,
  output logic dmaPopReady,
  output ipf_pkg::ipf_entry_t headEntry,
  // Transfer engine status
  input wire logic [NCH-1:0] pingpongXferActive,
  input wire logic [NCH-1:0] chanXferIntended,
  input wire logic [NCH-1:0] chanXferDone,
  output logic xferGlobalEnable,
  output logic fillIrq
);
  // ==========================================================
  // Reset synchroniser
  logic rstSync1_q;
  logic rstSync2_q;
  logic rstN;
  // Release is delayed two edges; assertion is immediate
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  assign rstN = rstSync2_q;
  // ==========================================================
  // State
  ipf_pkg::ipf_entry_t mem_q [ipf_pkg::DEPTH];  // Queue storage
  logic [2:0] wrPtr_q;  // Next slot to fill
  logic [2:0] rdPtr_q;  // Oldest slot
  logic [3:0] fill_q;  // Entries held, 0..8
  logic [3:0] coreWrIdx_q;  // Core writes done
  logic [3:0] coreRdIdx_q;  // Core reads done
  logic [7:0] ctrl_q;  // Control bits (bit 6 never stored)
  logic [NCH-1:0] ovf_q;  // Sticky overflow
  logic [NCH-1:0] xferAct_q;  // Standard transfer activity
  logic xferEnPrev_q;  // Edge detect of transfer enable
  logic pendRd_q;  // Core read waiting for data
  logic pendWr_q;  // Core write waiting for space
  logic [31:0] pendWdata_q;  // Word of the waiting write
  logic [31:0] rdata_q;
  logic rdValid_q;
  // ==========================================================
  // Decode
  wire selHead = regAddr == ipf_pkg::OFS_QUEUE_HEAD;
  wire selMain = regAddr == ipf_pkg::OFS_STATUS_MAIN;
  wire selIndex = regAddr == ipf_pkg::OFS_STATUS_INDEX;
  wire selCtrl = regAddr == ipf_pkg::OFS_PORT_CTRL;
  wire rdHead = regRd && selHead;
  wire wrHead = regWr && selHead;
  wire wrCtrl = regWr && selCtrl;  // Status registers take no writes
  wire portEn = ctrl_q[ipf_pkg::CTL_PORT_EN];
  wire stallDis = ctrl_q[ipf_pkg::CTL_STALL_DIS];
  wire [3:0] threshold = ctrl_q[ipf_pkg::CTL_THR_LSB +: ipf_pkg::CTL_THR_W];
  wire empty = fill_q == 4'h0;
  wire full = fill_q == ipf_pkg::FILL_FULL;
  // Port enable going low this cycle flushes the queue and index counters; overflow flags stay
  wire newPortEn = wrCtrl ? regWdata[ipf_pkg::CTL_PORT_EN] : portEn;
  wire flush = portEn && !newPortEn;
  wire ovfClr = wrCtrl && regWdata[ipf_pkg::CTL_OVF_CLR];
  // ==========================================================
  // Pop and push arbitration
  // Core read has priority over the transfer engine at the head
  wire popCore = (rdHead || pendRd_q) && !empty && !flush;
  wire popDma = dmaPop && !empty && !popCore && !flush;
  wire pop = popCore || popDma;
  // Samples enter only while enabled and space remains
  wire pushSample = sampleValid && portEn && !full && !flush;
  wire dropSample = sampleValid && portEn && full;
  // A colliding core write waits behind a sample
  wire coreWrReq = wrHead || pendWr_q;
  wire pushCore = coreWrReq && portEn && !full && !pushSample && !flush;
  wire push = pushSample || pushCore;
  wire [31:0] coreWord = pendWr_q ? pendWdata_q : regWdata;
  ipf_pkg::ipf_entry_t pushEntry;
  assign pushEntry = pushSample ? sampleIn.entry : ipf_pkg::ipf_entry_t'(coreWord);
  // Hold off an access that cannot complete now
  wire holdRd = rdHead && empty && !stallDis && portEn;
  wire holdWr = wrHead && !pushCore && portEn && !(full && stallDis);
  // ==========================================================
  // Queue storage, written at the tail
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wrPtr_q] <= pushEntry;  // Tag, side and sample kept as given
    end
  end
  // Oldest entry drives the head; parallel entries carry junk tag
  assign headEntry = mem_q[rdPtr_q];
  // ==========================================================
  // Pointers and fill level
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= 3'h0;
      rdPtr_q <= 3'h0;
      fill_q <= 4'h0;
    end else if (flush) begin
      wrPtr_q <= 3'h0;
      rdPtr_q <= 3'h0;
      fill_q <= 4'h0;
    end else begin
      wrPtr_q <= wrPtr_q + 3'(push);
      rdPtr_q <= rdPtr_q + 3'(pop);
      fill_q <= fill_q + 4'(push) - 4'(pop);
    end
  end
  // ==========================================================
  // Core index counters, saturating at eight
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      coreWrIdx_q <= 4'h0;
      coreRdIdx_q <= 4'h0;
    end else if (flush) begin
      coreWrIdx_q <= 4'h0;
      coreRdIdx_q <= 4'h0;
    end else begin
      if (pushCore && coreWrIdx_q != ipf_pkg::IDX_MAX) begin
        coreWrIdx_q <= coreWrIdx_q + 4'h1;
      end
      if (popCore && coreRdIdx_q != ipf_pkg::IDX_MAX) begin
        coreRdIdx_q <= coreRdIdx_q + 4'h1;
      end
    end
  end
  // ==========================================================
  // Pending core accesses
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      pendRd_q <= 1'b0;
      pendWr_q <= 1'b0;
      pendWdata_q <= 32'h0;
    end else begin
      // A disabled port would never fill, so waiting ends there
      pendRd_q <= (holdRd || (pendRd_q && !popCore)) && newPortEn;
      pendWr_q <= (holdWr || (pendWr_q && !pushCore)) && newPortEn;
      if (holdWr) begin
        pendWdata_q <= regWdata;
      end
    end
  end
  assign coreStall = pendRd_q || pendWr_q;
  assign dmaPopReady = !empty && !popCore && !flush;
  // ==========================================================
  // Control register
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ctrl_q <= ipf_pkg::CTL_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= regWdata[7:0] & ~(8'h01 << ipf_pkg::CTL_OVF_CLR);
    end
  end
  assign xferGlobalEnable = ctrl_q[ipf_pkg::CTL_XFER_EN];
  // ==========================================================
  // Sticky overflow; a new overflow wins over a clear
  logic [NCH-1:0] ovfSet;
  assign ovfSet = dropSample ? (NCH'(1) << sampleIn.entry.sourceChannelTag) : '0;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ovf_q <= '0;
    end else begin
      ovf_q <= (ovf_q & ~{NCH{ovfClr}}) | ovfSet;
    end
  end
  // ==========================================================
  // Standard transfer activity
  wire xferRise = xferGlobalEnable && !xferEnPrev_q;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      xferAct_q <= '0;
      xferEnPrev_q <= 1'b0;
    end else begin
      xferEnPrev_q <= xferGlobalEnable;
      if (!xferGlobalEnable) begin
        xferAct_q <= '0;
      end else if (xferRise) begin
        xferAct_q <= '1;
      end else begin
        xferAct_q <= xferAct_q & ~chanXferDone;
      end
    end
  end
  // Channels with nothing planned read high
  wire [NCH-1:0] xferStat = xferAct_q | ~chanXferIntended;
  // ==========================================================
  // Status words
  wire [31:0] statusMain = (32'(pingpongXferActive) << ipf_pkg::ST_PING_LSB)
    | (32'(ovf_q) << ipf_pkg::ST_OVF_LSB)
    | (32'(xferStat) << ipf_pkg::ST_XFER_LSB)
    | (32'(fill_q) << ipf_pkg::ST_FILL_LSB);
  wire [31:0] statusIndex = (32'(coreWrIdx_q) << ipf_pkg::IX_WR_LSB)
    | (32'(coreRdIdx_q) << ipf_pkg::IX_RD_LSB);
  wire [31:0] ctrlRead = {24'h0, ctrl_q};
  wire [31:0] headWord = empty ? 32'h0 : 32'(headEntry);
  wire [31:0] readMux = selHead ? headWord : selMain ? statusMain
    : selIndex ? statusIndex : selCtrl ? ctrlRead : 32'h0;
  // ==========================================================
  // Read data, one cycle after the strobe or after a stall ends
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      rdata_q <= 32'h0;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= (regRd && !holdRd) || (pendRd_q && (popCore || !newPortEn));
      if (pendRd_q) begin
        rdata_q <= popCore ? headWord : 32'h0;
      end else if (regRd) begin
        rdata_q <= readMux;
      end
    end
  end
  assign regRdata = rdata_q;
  assign regRdValid = rdValid_q;
  // Threshold interrupt; thresholds above seven never fire
  assign fillIrq = (threshold <= ipf_pkg::THR_MAX) && (fill_q > threshold);
  // ==========================================================
  // Checks
  sequence sFullSample;
    sampleValid && portEn && full;
  endsequence
  AST_FILL_LIMIT: assert property (@(posedge clock) disable iff (!rstN)
    fill_q <= ipf_pkg::FILL_FULL) else $error("fill level above eight");
  AST_FILL_TRACK: assert property (@(posedge clock) disable iff (!rstN)
    !flush |=> fill_q == $past(fill_q) + 4'($past(push)) - 4'($past(pop)))
    else $error("fill level lost track");
  AST_DROP_OVF: assert property (@(posedge clock) disable iff (!rstN)
    sFullSample |=> ovf_q[$past(sampleIn.entry.sourceChannelTag)])
    else $error("overflow not flagged");
  AST_OVF_CLR: assert property (@(posedge clock) disable iff (!rstN)
    ovfClr && !dropSample |=> ovf_q == '0) else $error("overflow not cleared");
  AST_FLUSH: assert property (@(posedge clock) disable iff (!rstN)
    flush |=> fill_q == 4'h0 ##1 (fill_q <= 4'h1)) else $error("flush failed");
  AST_NO_ENTRY: assert property (@(posedge clock) disable iff (!rstN)
    !portEn && !wrCtrl |=> fill_q <= $past(fill_q)) else $error("entry while disabled");
  // Watches every channel, so any completion pulse while transfers stay enabled exercises it
  AST_XFER_DONE: assert property (@(posedge clock) disable iff (!rstN)
    xferGlobalEnable && !xferRise && chanXferDone != '0
    |=> (xferAct_q & $past(chanXferDone)) == '0)
    else $error("activity stays after done");
  AST_XFER_SET: assert property (@(posedge clock) disable iff (!rstN)
    $rose(xferGlobalEnable) |-> xferAct_q == '0 ##1 xferAct_q == '1)
    else $error("activity not set by enable");
  AST_IRQ: assert property (@(posedge clock) disable iff (!rstN)
    threshold > ipf_pkg::THR_MAX |-> !fillIrq) else $error("irq above max threshold");
  AST_STALL: assert property (@(posedge clock) disable iff (!rstN)
    rdHead && empty && portEn && !stallDis |=> coreStall) else $error("no stall");
  AST_WR_IDX: assert property (@(posedge clock) disable iff (!rstN)
    pushCore && !flush && coreWrIdx_q < 4'h8 |=> coreWrIdx_q == $past(coreWrIdx_q) + 4'h1)
    else $error("write index not advanced");
  AST_RESERVED: assert property (@(posedge clock) disable iff (!rstN)
    statusMain[16] == 1'b0 && statusMain[27:25] == 3'h0 && statusIndex[31:8] == 24'h0)
    else $error("reserved bit set");
endmodule : ipf_input_port_fifo
`default_nettype wire

// ==== test/ipf_dma_model.sv ====
// Transfer engine model that drains the sample queue and reports per-channel completion.
`timescale 1ns/1ps
`default_nettype none
module ipf_dma_model #(
  parameter int XFER_LEN = 1
) (
  input wire logic clock,
  input wire logic popEn,
  input wire logic dmaPopReady,
  input wire ipf_pkg::ipf_entry_t headEntry,
  output logic dmaPop,
  output logic [7:0] chanXferDone
);
  // ==========================================================
  // Drain side
  // Words taken from the head, oldest first, for the bench to compare
  logic [31:0] got[$];
  // Words moved so far on each channel
  int cnt[8];
  // Pop only while offered, so a request never hangs on an empty queue
  assign dmaPop = popEn & dmaPopReady;
  initial chanXferDone = 8'h00;
  // Log each pop; flag a channel done once its programmed count has moved
  always @(posedge clock) begin
    chanXferDone <= 8'h00;
    if (dmaPop) begin
      got.push_back(headEntry);
      cnt[headEntry.sourceChannelTag]++;
      if (cnt[headEntry.sourceChannelTag] == XFER_LEN) begin
        chanXferDone[headEntry.sourceChannelTag] <= 1'b1;
      end
    end
  end
endmodule : ipf_dma_model
`default_nettype wire

// ==== test/ipf_input_port_fifo_tb.sv ====
// Self-checking bench for the sample queue output side and status registers.
`timescale 1ns/1ps
`default_nettype none
module ipf_input_port_fifo_tb;
  // ==========================================================
  // Signals
  logic clock;
  logic nrst;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic regRdValid;
  logic coreStall;
  logic sampleValid;
  ipf_pkg::ipf_sample_t sampleIn;
  logic dmaPop;
  logic dmaPopReady;
  ipf_pkg::ipf_entry_t headEntry;
  logic [7:0] ping;
  logic [7:0] intend;
  logic [7:0] done;
  logic xferEn;
  logic fillIrq;
  logic popEn;
  logic [31:0] rv;
  logic [31:0] rdSeen;
  int rdCnt;
  int n_mismatch;
  int checks;
  int cyc;
  ipf_input_port_fifo u_dut (.clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .regRdValid(regRdValid), .coreStall(coreStall), .sampleValid(sampleValid),
    .sampleIn(sampleIn), .dmaPop(dmaPop), .dmaPopReady(dmaPopReady),
    .headEntry(headEntry), .pingpongXferActive(ping), .chanXferIntended(intend),
    .chanXferDone(done), .xferGlobalEnable(xferEn), .fillIrq(fillIrq));
  ipf_dma_model u_dma (.clock(clock), .popEn(popEn), .dmaPopReady(dmaPopReady),
    .headEntry(headEntry), .dmaPop(dmaPop), .chanXferDone(done));
  // ==========================================================
  // Helpers
  // Distinct word per index: tag and side flag follow the index
  function automatic logic [31:0] ent(input int i);
    return {20'ha5a5a, i[7:0], i[0], i[2:0]};
  endfunction : ent
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One-cycle write, then one idle edge so strobes never toggle twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    d = regRdValid ? regRdata : 32'hdeadbeef;
    @(posedge clock);
  endtask : rd
  // Back-to-back serial samples starting at index first
  task automatic push(input int n, input int first);
    for (int k = 0; k < n; k++) begin
      sampleIn <= {1'b0, ent(first + k)};
      sampleValid <= 1'b1;
      @(posedge clock);
    end
    sampleValid <= 1'b0;
    @(posedge clock);
  endtask : push
  // Catches answers that arrive late, after a stalled read
  always @(posedge clock) begin
    if (regRdValid) begin
      rdSeen <= regRdata;
      rdCnt++;
    end
  end
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    ping <= 8'h81;
    intend <= 8'hf7;
    rd(ipf_pkg::OFS_STATUS_MAIN, rv);
    chk("status", rv, 32'h0010_0081);
    wr(ipf_pkg::OFS_STATUS_MAIN, 32'hffff_ffff);
    rd(ipf_pkg::OFS_STATUS_MAIN, rv);
    chk("status ro", rv, 32'h0010_0081);
    rd(8'h10, rv);
    chk("unmapped", rv, 32'h0);
    wr(ipf_pkg::OFS_PORT_CTRL, 32'hd3);
    rd(ipf_pkg::OFS_PORT_CTRL, rv);
    chk("ctrl", rv, 32'h93);
    ping <= 8'h00;
    intend <= 8'hff;
  endtask : t_regs
  task automatic t_fill();
    wr(ipf_pkg::OFS_PORT_CTRL, 32'h80);
    push(8, 0);
    rd(ipf_pkg::OFS_STATUS_MAIN, rv);
    chk("fill full", rv, 32'h8000_0000);
    push(1, 5);
    rd(ipf_pkg::OFS_STATUS_MAIN, rv);
    chk("overflow", rv, 32'h8000_2000);
    rd(ipf_pkg::OFS_QUEUE_HEAD, rv);
    chk("head", rv, ent(0));
    rd(ipf_pkg::OFS_STATUS_INDEX, rv);
    chk("read index", rv, 32'h10);
    wr(ipf_pkg::OFS_QUEUE_HEAD, ent(9));
    rd(ipf_pkg::OFS_STATUS_INDEX, rv);
    chk("write index", rv, 32'h11);
    wr(ipf_pkg::OFS_PORT_CTRL, 32'hc0);
    rd(ipf_pkg::OFS_STATUS_MAIN, rv);
    chk("ovf clear", rv, 32'h8000_0000);
    wr(ipf_pkg::OFS_PORT_CTRL, 32'ha7);
    chk("irq thr 7", {31'h0, fillIrq}, 32'h1);
    chk("xfer enable", {31'h0, xferEn}, 32'h1);
    wr(ipf_pkg::OFS_PORT_CTRL, 32'ha8);
    chk("irq thr 8", {31'h0, fillIrq}, 32'h0);
    rd(ipf_pkg::OFS_STATUS_MAIN, rv);
    chk("xfer active", rv, 32'h81fe_0000);
    popEn <= 1'b1;
    for (int k = 0; k < 20 && u_dma.got.size() < 8; k++) @(posedge clock);
    popEn <= 1'b0;
    @(posedge clock);
    chk("pops", u_dma.got.size(), 32'h8);
    for (int k = 0; k < 8; k++) chk("pop order", u_dma.got[k], ent(k < 7 ? k + 1 : 9));
    rd(ipf_pkg::OFS_STATUS_MAIN, rv);
    chk("xfer done", rv, 32'h0002_0000);
  endtask : t_fill
  task automatic t_stall();
    int n0;
    wr(ipf_pkg::OFS_PORT_CTRL, 32'h80);
    chk("xfer off", {31'h0, xferEn}, 32'h0);
    n0 = rdCnt;
    regAddr <= ipf_pkg::OFS_QUEUE_HEAD;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    repeat (3) @(posedge clock);
    chk("stall on", {31'h0, coreStall}, 32'h1);
    push(1, 3);
    for (int k = 0; k < 10 && rdCnt == n0; k++) @(posedge clock);
    #1;
    chk("stall data", rdSeen, ent(3));
    chk("stall off", {31'h0, coreStall}, 32'h0);
  endtask : t_stall
  task automatic t_flush();
    push(3, 0);
    wr(ipf_pkg::OFS_PORT_CTRL, 32'h00);
    rd(ipf_pkg::OFS_STATUS_MAIN, rv);
    chk("flushed", rv, 32'h0);
    rd(ipf_pkg::OFS_STATUS_INDEX, rv);
    chk("index flushed", rv, 32'h0);
    push(1, 4);
    rd(ipf_pkg::OFS_STATUS_MAIN, rv);
    chk("disabled", rv, 32'h0);
    wr(ipf_pkg::OFS_PORT_CTRL, 32'h90);
    rd(ipf_pkg::OFS_QUEUE_HEAD, rv);
    chk("empty read", rv, 32'h0);
    chk("no stall", {31'h0, coreStall}, 32'h0);
  endtask : t_flush
  // ==========================================================
  // Verdict, clock, sequence and hang guard
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    nrst = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    sampleValid = 1'b0;
    sampleIn = '0;
    ping = 8'h00;
    intend = 8'hff;
    popEn = 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_fill();
    t_stall();
    t_flush();
    report_and_stop();
  end
  // Whole run needs about a hundred cycles; far above that means a hang
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
endmodule : ipf_input_port_fifo_tb
`default_nettype wire
